// >>> hw/input_sync.sv
module input_sync
    import servo_io_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // Two flops before any logic sees a pin.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// >>> hw/probe_capture.sv
module probe_capture
    import servo_io_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Trigger and position
    input  wire logic             trigger,
    input  wire logic [POS_W-1:0] position,
    // Captured value
    output logic      [POS_W-1:0] held_pos,
    output logic                  held_valid
);

    logic trigger_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trigger_q <= 1'b0;
        end else begin
            trigger_q <= trigger;
        end
    end

    // A rising trigger latches the position; it is held until the next one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_pos   <= '0;
            held_valid <= 1'b0;
        end else if (trigger && !trigger_q) begin
            held_pos   <= position;
            held_valid <= 1'b1;
        end
    end

endmodule

// >>> hw/servo_io_device_logic.sv
module servo_io_device_logic
    import servo_io_pkg::*;
#(
    parameter int FAULT_RELEASE_CYCLES = FAULT_RELEASE_CYC
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Input devices from the connector
    input  wire logic                    forced_stop_decel_in,
    input  wire logic                    forced_stop_brake_in,
    input  wire logic                    fwd_limit_in,
    input  wire logic                    rev_limit_in,
    input  wire logic                    proportional_only_in,
    input  wire logic                    gain_set_a_in,
    input  wire logic                    gain_set_b_in,
    input  wire logic                    proximity_dog_in,
    input  wire logic                    full_loop_select_in,
    input  wire logic                    probe_latch_a_in,
    input  wire logic                    probe_latch_b_in,
    input  wire logic                    probe_latch_c_in,
    // Configuration
    input  wire logic [1:0]              stop_select_cfg,
    input  wire logic                    forced_stop_disable_cfg,
    input  wire logic [POS_W-1:0]        in_position_range_cfg,
    input  wire logic                    proximity_polarity_cfg,
    input  wire logic                    loop_switch_enable_cfg,
    // Control core status
    input  wire logic                    servo_on_req,
    input  wire logic                    alarm,
    input  wire logic [1:0]              ctrl_mode,
    input  wire logic                    decel_done,
    input  wire logic signed [POS_W-1:0] droop,
    input  wire logic [POS_W-1:0]        position,
    input  wire logic signed [SPD_W-1:0] motor_speed,
    input  wire logic [SPD_W-1:0]        set_speed,
    // Commands to the control core
    output logic                         base_enable,
    output logic                         dynamic_brake,
    output logic                         decel_stop,
    output logic                         servo_lock,
    output logic                         fwd_allow,
    output logic                         rev_allow,
    output logic                         proportional_only,
    output logic [1:0]                   gain_select,
    output logic                         dog_detect,
    output logic                         full_loop,
    // Touch probe captures
    output logic [POS_W-1:0]             probe_pos_a,
    output logic [POS_W-1:0]             probe_pos_b,
    output logic [POS_W-1:0]             probe_pos_c,
    output logic [2:0]                   probe_valid,
    // Output devices
    output logic                         fault_n_out,
    output logic                         in_position_out,
    output logic                         ready_out,
    output logic                         speed_reached_out,
    output logic                         brake_interlock_out
);

    // ------------------------------------------------------------------
    // Reset release and input synchronisation
    // ------------------------------------------------------------------
    logic              rst_meta;
    logic              rst_sync_n;
    logic [SYNC_W-1:0] pins;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    input_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_sync_n),
        .async_in ({forced_stop_decel_in, forced_stop_brake_in, fwd_limit_in,
                    rev_limit_in, proportional_only_in, gain_set_a_in,
                    gain_set_b_in, proximity_dog_in, full_loop_select_in,
                    probe_latch_b_in, probe_latch_c_in}),
        .sync_out (pins)
    );

    logic fs2;
    logic fs1;
    logic fwd_on;
    logic rev_on;
    logic prop_on;
    logic gain_a;
    logic gain_b;
    logic dog_on;
    logic loop_on;
    logic probe_b;
    logic probe_c;
    logic probe_a;

    assign {fs2, fs1, fwd_on, rev_on, prop_on, gain_a, gain_b,
            dog_on, loop_on, probe_b, probe_c} = pins;

    input_sync #(
        .WIDTH (1)
    ) u_sync_probe_a (
        .clk      (clk),
        .rst_n    (rst_sync_n),
        .async_in (probe_latch_a_in),
        .sync_out (probe_a)
    );

    // ------------------------------------------------------------------
    // Forced-stop decoding
    // ------------------------------------------------------------------
    function automatic logic [SPD_W-1:0] abs_speed(input logic signed [SPD_W-1:0] v);
        abs_speed = v[SPD_W-1] ? SPD_W'(-v) : SPD_W'(v);
    endfunction

    logic torque_mode;
    logic decel_style;
    logic hard_stop;
    logic soft_stop;

    assign torque_mode = (ctrl_mode == MODE_TORQUE);
    // Deceleration is only used with the second input selected, outside torque.
    assign decel_style = (stop_select_cfg == STOP_SEL_FS2) && !torque_mode;
    assign hard_stop = !forced_stop_disable_cfg && (
        ((stop_select_cfg == STOP_SEL_FS1) && !fs1) ||
        ((stop_select_cfg == STOP_SEL_FS2) && torque_mode && !fs2));
    assign soft_stop = !forced_stop_disable_cfg && decel_style && !fs2;

    // ------------------------------------------------------------------
    // Power-on fault release timer
    // ------------------------------------------------------------------
    logic [31:0] boot_count;
    logic        boot_done;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            boot_count <= '0;
            boot_done  <= 1'b0;
        end else if (!boot_done) begin
            boot_count <= boot_count + 32'h0000_0001;
            boot_done  <= (boot_count == 32'(FAULT_RELEASE_CYCLES - 1));
        end
    end

    // ------------------------------------------------------------------
    // Servo state machine
    // ------------------------------------------------------------------
    servo_state_t state;
    servo_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (servo_on_req && boot_done && !alarm && !hard_stop && !soft_stop) begin
                    next_state = ST_ON;
                end
            end
            ST_ON: begin
                if (!servo_on_req) begin
                    next_state = ST_OFF;
                end else if (hard_stop || (alarm && !decel_style)) begin
                    next_state = ST_TRIP;
                end else if (soft_stop || alarm) begin
                    next_state = ST_DECEL;
                end
            end
            ST_DECEL: begin
                if (hard_stop || decel_done) begin
                    next_state = ST_TRIP;
                end else if (!soft_stop && !alarm) begin
                    next_state = ST_ON;
                end
            end
            ST_TRIP: begin
                if (!servo_on_req) begin
                    next_state = ST_OFF;
                end else if (!hard_stop && !soft_stop && !alarm) begin
                    next_state = ST_ON;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Drive commands and servo outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            base_enable         <= 1'b0;
            dynamic_brake       <= 1'b1;
            decel_stop          <= 1'b0;
            ready_out           <= 1'b0;
            brake_interlock_out <= 1'b0;
            fault_n_out         <= 1'b0;
        end else begin
            base_enable         <= (next_state == ST_ON) || (next_state == ST_DECEL);
            dynamic_brake       <= !((next_state == ST_ON) || (next_state == ST_DECEL));
            decel_stop          <= (next_state == ST_DECEL);
            ready_out           <= (next_state == ST_ON);
            brake_interlock_out <= (next_state == ST_ON) || (next_state == ST_DECEL);
            fault_n_out         <= boot_done && !alarm;
        end
    end

    // ------------------------------------------------------------------
    // Stroke limits, loop and gain selection
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fwd_allow         <= 1'b0;
            rev_allow         <= 1'b0;
            servo_lock        <= 1'b0;
            proportional_only <= 1'b0;
            gain_select       <= GAIN_NORMAL;
            dog_detect        <= 1'b0;
            full_loop         <= 1'b0;
        end else begin
            fwd_allow         <= fwd_on;
            rev_allow         <= rev_on;
            servo_lock        <= (state == ST_ON) && !(fwd_on && rev_on);
            proportional_only <= prop_on;
            gain_select       <= gain_b ? GAIN_ALT_B : (gain_a ? GAIN_ALT_A : GAIN_NORMAL);
            dog_detect        <= proximity_polarity_cfg ? !dog_on : dog_on;
            full_loop         <= loop_switch_enable_cfg && loop_on;
        end
    end

    // ------------------------------------------------------------------
    // In-position and speed reached
    // ------------------------------------------------------------------
    logic [POS_W-1:0] droop_mag;
    logic [SPD_W-1:0] speed_err;
    logic [SPD_W-1:0] speed_win;
    logic signed [SPD_W:0] speed_diff;

    assign droop_mag  = droop[POS_W-1] ? POS_W'(-droop) : POS_W'(droop);
    assign speed_diff = (SPD_W+1)'(abs_speed(motor_speed)) - (SPD_W+1)'(set_speed);
    assign speed_err  = speed_diff[SPD_W] ? SPD_W'(-speed_diff) : speed_diff[SPD_W-1:0];
    assign speed_win  = (set_speed / SPEED_RATIO_DIV) + SPEED_MARGIN_RPM;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            in_position_out   <= 1'b0;
            speed_reached_out <= 1'b0;
        end else begin
            in_position_out <= (ctrl_mode == MODE_POSITION) &&
                               (droop_mag <= in_position_range_cfg);
            if (ctrl_mode != MODE_VELOCITY || state != ST_ON) begin
                speed_reached_out <= 1'b0;
            end else if (set_speed <= SPEED_MARGIN_RPM) begin
                speed_reached_out <= 1'b1;
            end else begin
                speed_reached_out <= (speed_err <= speed_win);
            end
        end
    end

    // ------------------------------------------------------------------
    // Touch probes
    // ------------------------------------------------------------------
    probe_capture u_probe_a (
        .clk        (clk),
        .rst_n      (rst_sync_n),
        .trigger    (probe_a),
        .position   (position),
        .held_pos   (probe_pos_a),
        .held_valid (probe_valid[0])
    );

    probe_capture u_probe_b (
        .clk        (clk),
        .rst_n      (rst_sync_n),
        .trigger    (probe_b),
        .position   (position),
        .held_pos   (probe_pos_b),
        .held_valid (probe_valid[1])
    );

    probe_capture u_probe_c (
        .clk        (clk),
        .rst_n      (rst_sync_n),
        .trigger    (probe_c),
        .position   (position),
        .held_pos   (probe_pos_c),
        .held_valid (probe_valid[2])
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    fault_alarm_a: assert property (alarm |=> !fault_n_out)
        else $error("fault output high during alarm");
    fault_boot_a: assert property (!boot_done |=> !fault_n_out)
        else $error("fault output rose before power-up time");
    brake_now_a: assert property (
        (state == ST_ON) && servo_on_req && hard_stop |=> !brake_interlock_out && !base_enable)
        else $error("brake interlock not dropped at once");
    decel_hold_a: assert property (
        (state == ST_ON) && servo_on_req && soft_stop && !hard_stop |=> decel_stop && brake_interlock_out)
        else $error("deceleration stop not started");
    decel_end_a: assert property (
        (state == ST_DECEL) && decel_done |=> (state == ST_TRIP) && !brake_interlock_out)
        else $error("brake interlock kept after deceleration");
    trip_release_a: assert property (
        (state == ST_TRIP) && servo_on_req && !hard_stop && !soft_stop && !alarm |=> ready_out)
        else $error("forced stop not released");
    ready_state_a: assert property (ready_out == (state == ST_ON))
        else $error("ready output disagrees with servo state");
    gain_prio_a: assert property (gain_b ##1 gain_b |-> gain_select == GAIN_ALT_B)
        else $error("second gain select lost priority");
    inpos_mode_a: assert property ((ctrl_mode != MODE_POSITION) |=> !in_position_out)
        else $error("in-position active outside position mode");
    speed_off_a: assert property ((state != ST_ON) |=> !speed_reached_out)
        else $error("speed reached active at servo off");
    brake_off_a: assert property ((state == ST_OFF) |-> !brake_interlock_out)
        else $error("brake interlock on at servo off");

    cover_decel_c: cover property ((state == ST_ON) ##1 (state == ST_DECEL) ##[1:50] (state == ST_TRIP));
    cover_rearm_c: cover property ((state == ST_DECEL) ##1 (state == ST_ON));
    cover_speed_c: cover property (speed_reached_out && (set_speed > SPEED_MARGIN_RPM));
    cover_probe_c: cover property ($rose(probe_valid[0]));

endmodule

// >>> pkg/servo_io_pkg.sv
package servo_io_pkg;

    // ------------------------------------------------------------------
    // Control modes and configuration codes
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_POSITION = 2'h0;
    localparam logic [1:0] MODE_VELOCITY = 2'h1;
    localparam logic [1:0] MODE_TORQUE   = 2'h2;
    localparam logic [1:0] STOP_SEL_FS1  = 2'h0;
    localparam logic [1:0] STOP_SEL_FS2  = 2'h2;
    localparam logic [1:0] GAIN_NORMAL   = 2'h0;
    localparam logic [1:0] GAIN_ALT_A    = 2'h1;
    localparam logic [1:0] GAIN_ALT_B    = 2'h2;

    // ------------------------------------------------------------------
    // Widths, speed window and timing
    // ------------------------------------------------------------------
    localparam int POS_W = 32;
    localparam int SPD_W = 16;
    localparam int SYNC_W = 11;
    localparam logic [15:0] SPEED_MARGIN_RPM = 16'h0014;
    localparam logic [15:0] SPEED_RATIO_DIV  = 16'h0014;
    localparam int CLK_HZ = 10_000_000;
    localparam int FAULT_RELEASE_MS = 3000;
    localparam int FAULT_RELEASE_CYC = FAULT_RELEASE_MS * (CLK_HZ / 1000);

    typedef enum logic [3:0] {
        ST_OFF   = 4'b0001,
        ST_ON    = 4'b0010,
        ST_DECEL = 4'b0100,
        ST_TRIP  = 4'b1000
    } servo_state_t;

endpackage

// >>> verification/io_far_side.sv
module io_far_side
    import servo_io_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Requested pin levels and control mode
    input  wire logic [11:0] pin_req,
    input  wire logic [1:0]  mode,
    // Connector pins
    output logic      [11:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // The proportional control pin is always driven low in torque mode, whatever is requested.
    always_ff @(posedge clk) begin
        pins <= (mode == MODE_TORQUE) ? (pin_req & 12'hfef) : pin_req;
    end
endmodule

// >>> verification/servo_io_device_logic_tb.sv
module servo_io_device_logic_tb
    import servo_io_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [11:0] p;
        logic [1:0]  m;
        logic        pol;
        logic [15:0] set;
        logic [15:0] spd;
        logic [31:0] dr;
        logic [8:0]  e;
    } row_t;
    // Pin order: 0 decel stop, 1 brake stop, 2 fwd, 3 rev, 4 prop, 5 gain a, 6 gain b,
    // 7 dog, 8 loop select, 9..11 probes a..c.
    row_t rows [6] = '{
        '{12'h00f, MODE_POSITION, 1'b0, 16'h0000, 16'h0000, 32'hffff_fff0, 9'h013},
        '{12'h02f, MODE_POSITION, 1'b1, 16'h0000, 16'h0000, 32'h0000_0011, 9'h0c3},
        '{12'h1ff, MODE_VELOCITY, 1'b0, 16'h03e8, 16'h042e, 32'h0000_0000, 9'h16f},
        '{12'h00b, MODE_VELOCITY, 1'b0, 16'h03e8, 16'hfbd1, 32'h0000_0000, 9'h001},
        '{12'h017, MODE_VELOCITY, 1'b0, 16'h0014, 16'h01f4, 32'h0000_0000, 9'h00e},
        '{12'h01f, MODE_TORQUE,   1'b0, 16'h03e8, 16'h03e8, 32'h0000_0000, 9'h003}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] pin_req = 12'h00f;
    logic [11:0] pins;
    logic [1:0]  sel = STOP_SEL_FS2;
    logic        dis = 1'b0;
    logic        pol = 1'b0;
    logic        loop_en = 1'b1;
    logic        son = 1'b1;
    logic        alarm = 1'b0;
    logic [1:0]  mode = MODE_VELOCITY;
    logic        ddone = 1'b0;
    logic signed [POS_W-1:0] droop = '0;
    logic [POS_W-1:0] pos = 32'h1234_5678;
    logic signed [SPD_W-1:0] spd = '0;
    logic [SPD_W-1:0] set = '0;
    logic base_enable, dynamic_brake, decel_stop, fwd_allow, rev_allow, proportional_only;
    logic dog_detect, full_loop, fault_n_out, in_position_out, ready_out;
    logic speed_reached_out, brake_interlock_out, servo_lock;
    logic [1:0] gain_select;
    logic [2:0] probe_valid;
    logic [POS_W-1:0] ppos [3];
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;

    initial begin
        forever #50 clk = ~clk;
    end

    io_far_side u_io_far_side (.clk(clk), .pin_req(pin_req), .mode(mode), .pins(pins));

    servo_io_device_logic #(.FAULT_RELEASE_CYCLES(20)) u_servo_io_device_logic (
        .clk(clk), .rst_n(rst_n),
        .forced_stop_decel_in(pins[0]), .forced_stop_brake_in(pins[1]),
        .fwd_limit_in(pins[2]), .rev_limit_in(pins[3]), .proportional_only_in(pins[4]),
        .gain_set_a_in(pins[5]), .gain_set_b_in(pins[6]), .proximity_dog_in(pins[7]),
        .full_loop_select_in(pins[8]), .probe_latch_a_in(pins[9]),
        .probe_latch_b_in(pins[10]), .probe_latch_c_in(pins[11]),
        .stop_select_cfg(sel), .forced_stop_disable_cfg(dis),
        .in_position_range_cfg(32'h0000_0010), .proximity_polarity_cfg(pol),
        .loop_switch_enable_cfg(loop_en), .servo_on_req(son), .alarm(alarm), .ctrl_mode(mode),
        .decel_done(ddone), .droop(droop), .position(pos), .motor_speed(spd),
        .set_speed(set), .base_enable(base_enable), .dynamic_brake(dynamic_brake),
        .decel_stop(decel_stop), .servo_lock(servo_lock), .fwd_allow(fwd_allow),
        .rev_allow(rev_allow), .proportional_only(proportional_only),
        .gain_select(gain_select), .dog_detect(dog_detect), .full_loop(full_loop),
        .probe_pos_a(ppos[0]), .probe_pos_b(ppos[1]), .probe_pos_c(ppos[2]),
        .probe_valid(probe_valid), .fault_n_out(fault_n_out),
        .in_position_out(in_position_out), .ready_out(ready_out),
        .speed_reached_out(speed_reached_out), .brake_interlock_out(brake_interlock_out));

    task automatic chk(input logic [32:0] seen, input logic [32:0] want);
        total_checks++;
        if (seen !== want) begin
            err_count++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (ready_out !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        chk(ready_out, 1'b1);
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // A hang is cut short after many more cycles than the tests need.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        settle(3);
        chk({ready_out, dynamic_brake, fault_n_out}, 3'h2);
        settle(2);
        @(posedge clk);
        rst_n <= 1'b1;
        settle(5);
        chk(fault_n_out, 1'b0);
        wait_ready();
        chk({fault_n_out, ready_out, base_enable, brake_interlock_out}, 4'hf);
        $display("test reset and power-up done");
        foreach (rows[i]) begin
            @(posedge clk);
            pin_req <= rows[i].p;
            mode <= rows[i].m;
            pol <= rows[i].pol;
            set <= rows[i].set;
            spd <= rows[i].spd;
            droop <= rows[i].dr;
            settle(6);
            chk({gain_select, dog_detect, full_loop, in_position_out, speed_reached_out,
                 proportional_only, fwd_allow, rev_allow}, rows[i].e);
            chk(servo_lock, !(rows[i].p[2] && rows[i].p[3]));
        end
        @(posedge clk);
        pin_req <= 12'h00f;
        mode <= MODE_VELOCITY;
        $display("test device table done");
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            pin_req[9+k] <= 1'b1;
            pos <= 32'h0a0b_0c00 + k;
            settle(5);
            @(posedge clk);
            pos <= 32'hffff_0000;
            settle(2);
            chk({probe_valid[k], ppos[k]}, {1'b1, 32'h0a0b_0c00 + k});
        end
        $display("test probe capture done");
        @(posedge clk);
        loop_en <= 1'b0;
        pin_req[8] <= 1'b1;
        settle(6);
        chk(full_loop, 1'b0);
        @(posedge clk);
        loop_en <= 1'b1;
        settle(1);
        chk(full_loop, 1'b1);
        $display("test loop switch enable done");
        @(posedge clk);
        pin_req[0] <= 1'b0;
        settle(6);
        chk({decel_stop, brake_interlock_out, base_enable}, 3'h7);
        @(posedge clk);
        ddone <= 1'b1;
        @(posedge clk);
        ddone <= 1'b0;
        settle(2);
        chk({decel_stop, brake_interlock_out, base_enable, dynamic_brake}, 4'h1);
        @(posedge clk);
        pin_req[0] <= 1'b1;
        wait_ready();
        chk(ready_out, 1'b1);
        $display("test decelerating stop done");
        @(posedge clk);
        sel <= STOP_SEL_FS1;
        pin_req[1] <= 1'b0;
        settle(6);
        chk({decel_stop, brake_interlock_out, base_enable, dynamic_brake, fault_n_out}, 5'h3);
        @(posedge clk);
        pin_req[1] <= 1'b1;
        wait_ready();
        chk(ready_out, 1'b1);
        @(posedge clk);
        sel <= STOP_SEL_FS2;
        mode <= MODE_TORQUE;
        pin_req[0] <= 1'b0;
        settle(6);
        chk({decel_stop, base_enable, dynamic_brake}, 3'h1);
        @(posedge clk);
        pin_req[0] <= 1'b1;
        mode <= MODE_VELOCITY;
        wait_ready();
        $display("test hard stop done");
        @(posedge clk);
        sel <= STOP_SEL_FS1;
        dis <= 1'b1;
        pin_req[1:0] <= 2'h0;
        settle(6);
        chk({ready_out, base_enable}, 2'h3);
        @(posedge clk);
        alarm <= 1'b1;
        settle(3);
        chk({brake_interlock_out, fault_n_out, base_enable}, 3'h0);
        $display("test disable and alarm done");
        print_verdict();
    end
endmodule
